// *** rtl/servo_ctrl.sv ***
// Stepper servo controller for the vacuum tuning capacitor.
`timescale 1ns/1ps
module servo_ctrl #(
  parameter int unsigned RAMP_CYCLES  = servo_pkg::RAMP_CYCLES,
  parameter int unsigned RESET_CYCLES = servo_pkg::RESET_CYCLES
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 aux_supply_pending_input_i,
  input  wire logic                 run_inhibit_input_i,
  input  wire logic                 auto_manual_select_i,
  input  wire logic                 zero_position_sensor_i,
  input  wire logic                 start_button_i,
  input  wire logic [12:0]          panel_position_switches_i,
  input  wire logic [11:0]          freq_count_i,
  input  wire servo_pkg::bus_req_s  bus_i,
  output logic      [31:0]          rdata_o,
  output logic      [3:0]           phase_o,
  output logic                      high_supply_o,
  output logic                      end_stop_output_o,
  output logic                      end_stop_lamp_o,
  output logic                      error_output_o,
  output logic                      error_lamp_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Converts a three-and-a-half digit BCD entry to binary.
  function automatic logic [11:0] bcd_to_bin(input logic [12:0] bcd);
    logic [11:0] th;
    logic [11:0] hu;
    logic [11:0] te;
    logic [11:0] un;
    th = {11'h000, bcd[12]};
    hu = {8'h00, bcd[11:8]};
    te = {8'h00, bcd[7:4]};
    un = {8'h00, bcd[3:0]};
    bcd_to_bin = 12'(th * 12'd1000 + hu * 12'd100 + te * 12'd10 + un);
  endfunction : bcd_to_bin

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic [12:0] panel1;
  logic [12:0] panel2;
  logic [11:0] freq1;
  logic [11:0] freq2;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1  <= 5'h02;
      sync2  <= 5'h02;
      panel1 <= 13'h0000;
      panel2 <= 13'h0000;
      freq1  <= 12'h000;
      freq2  <= 12'h000;
    end else begin
      sync1  <= {start_button_i, zero_position_sensor_i,
                 auto_manual_select_i, aux_supply_pending_input_i,
                 run_inhibit_input_i};
      sync2  <= sync1;
      panel1 <= panel_position_switches_i;
      panel2 <= panel1;
      freq1  <= freq_count_i;
      freq2  <= freq1;
    end
  end

  logic run_inhibit;
  logic aux_pending;
  logic auto_mode;
  logic zero_sense;
  logic start_btn;

  assign run_inhibit = sync2[0];
  assign aux_pending = sync2[1];
  assign auto_mode   = sync2[2];
  assign zero_sense  = sync2[3];
  assign start_btn   = sync2[4];

  logic zero_prev;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zero_prev <= 1'b0;
    end else begin
      zero_prev <= zero_sense;
    end
  end

  logic zero_rise;
  assign zero_rise = zero_sense & ~zero_prev;

  // ****************************************************************
  // Target selection and comparison
  // ****************************************************************

  logic [11:0] position;
  logic [11:0] target;
  logic        initiating;
  logic        zero_found;

  assign target = auto_mode ? freq2
                            : bcd_to_bin(panel2);

  logic dir_up;
  logic coincide;
  logic at_low;
  logic at_high;
  logic limit_stop;

  // The initiation latch overrides the comparator and both end stops.
  assign dir_up     = ~initiating & (target > position);
  assign coincide   = zero_found & ~initiating
                      & (target == position);
  assign at_low     = ~initiating & (position == servo_pkg::POS_LOW);
  assign at_high    = ~initiating & (position == servo_pkg::POS_HIGH);
  assign limit_stop = (at_low & ~dir_up)
                      | (at_high & dir_up);

  // ****************************************************************
  // Initiation latch
  // ****************************************************************

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      initiating <= 1'b1;
      zero_found <= 1'b0;
    end else if (aux_pending) begin
      initiating <= 1'b1;
    end else if (initiating && zero_sense) begin
      initiating <= 1'b0;
      zero_found <= 1'b1;
    end
  end

  // ****************************************************************
  // Speed ramp
  // ****************************************************************

  logic        running;
  logic        next_running;
  logic        ramp_ready;
  logic [23:0] reset_cnt;
  logic [23:0] ramp_cnt;
  logic [7:0]  frac;

  // Ramp must fully reset before a stopped motor may start again.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_ready <= 1'b0;
      reset_cnt  <= 24'h000000;
    end else if (zero_rise) begin
      ramp_ready <= 1'b0;
      reset_cnt  <= 24'h000000;
    end else if (running && !next_running) begin
      ramp_ready <= 1'b0;
      reset_cnt  <= 24'h000000;
    end else if (!running && !ramp_ready) begin
      if (reset_cnt >= 24'(RESET_CYCLES - 1)) begin
        ramp_ready <= 1'b1;
      end else begin
        reset_cnt <= reset_cnt + 24'h000001;
      end
    end else if (!running && ramp_ready) begin
      reset_cnt <= 24'h000000;
    end
  end

  localparam int unsigned FRAC_STEP = RAMP_CYCLES / 256;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ramp_cnt <= 24'h000000;
      frac     <= 8'h00;
    end else if (!running) begin
      ramp_cnt <= 24'h000000;
      frac     <= 8'h00;
    end else if (frac != 8'hFF) begin
      if (ramp_cnt >= 24'(FRAC_STEP - 1)) begin
        ramp_cnt <= 24'h000000;
        frac     <= frac + 8'h01;
      end else begin
        ramp_cnt <= ramp_cnt + 24'h000001;
      end
    end
  end

  logic [15:0] step_rate;
  logic [23:0] acc;
  logic [24:0] acc_sum;
  logic [23:0] inc;
  logic        step;

  // Rate grows linearly from the base rate to just under twice it, as frac stops at 8'hFF.
  assign inc     = {8'h00, step_rate}
                   + 24'(({8'h00, step_rate} * {16'h0000, frac}) >> 8);
  assign acc_sum = {1'b0, acc} + {1'b0, inc};
  assign step    = running & acc_sum[24];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc <= 24'h000000;
    end else if (!running) begin
      acc <= 24'h000000;
    end else begin
      acc <= acc_sum[23:0];
    end
  end

  // ****************************************************************
  // Run gating
  // ****************************************************************

  logic zero_start;
  logic run_req;

  // Zero detection arms a restart that fires once the ramp is reset.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zero_start <= 1'b0;
    end else if (zero_rise) begin
      zero_start <= 1'b1;
    end else if ((running && ramp_ready) || coincide) begin
      zero_start <= 1'b0;
    end
  end

  always_comb begin
    run_req = initiating
              | (~coincide & ~limit_stop
                 & (zero_start
                    | (~auto_mode & start_btn)
                    | (auto_mode & (target != position))
                    | running));
    next_running = run_req & ~run_inhibit & ~aux_pending
                   & ramp_ready;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      running <= 1'b0;
    end else begin
      running <= next_running;
    end
  end

  // ****************************************************************
  // Position counter and phase generator
  // ****************************************************************

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      position <= 12'h000;
    end else if (initiating && zero_sense) begin
      position <= 12'h000;
    end else if (step && !initiating) begin
      position <= dir_up ? position + 12'h001
                         : position - 12'h001;
    end
  end

  logic q_a;
  logic q_b;

  // Gray sequence: up walks 00-01-11-10, down walks it backwards.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_a <= 1'b0;
      q_b <= 1'b0;
    end else if (step) begin
      q_a <= dir_up ? q_b : ~q_b;
      q_b <= dir_up ? ~q_a : q_a;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_o <= 4'h0;
    end else begin
      phase_o <= {q_a & ~q_b, q_a & q_b,
                  ~q_a & q_b, ~q_a & ~q_b};
    end
  end

  // ****************************************************************
  // Indicators and supply select
  // ****************************************************************

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_supply_o     <= 1'b0;
      end_stop_output_o <= 1'b0;
      end_stop_lamp_o   <= 1'b0;
      error_output_o    <= 1'b0;
      error_lamp_o      <= 1'b0;
    end else begin
      high_supply_o     <= next_running;
      end_stop_output_o <= at_low | at_high;
      end_stop_lamp_o   <= at_low | at_high;
      error_output_o    <= ~coincide & zero_found;
      error_lamp_o      <= ~coincide & zero_found;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************

  servo_pkg::status_s status;

  assign status = '{coincide:   coincide,
                    end_stop:   at_low | at_high,
                    initiating: initiating,
                    running:    running,
                    position:   position};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_rate <= servo_pkg::STEP_RATE_RST;
    end else if (bus_i.wr && bus_i.addr == servo_pkg::ADDR_STEP_RATE) begin
      step_rate <= bus_i.wdata[15:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        servo_pkg::ADDR_STEP_RATE: rdata_o <= {16'h0000, step_rate};
        servo_pkg::ADDR_STATUS:    rdata_o <= {16'h0000, status};
        servo_pkg::ADDR_TARGET:    rdata_o <= {20'h00000, target};
        default:                   rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

endmodule : servo_ctrl

// *** rtl/servo_pkg.sv ***
// Constants, types and bus map of the capacitor servo controller.
package servo_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned RAMP_MS       = 220;
  localparam int unsigned RAMP_RESET_MS = 20;
  localparam int unsigned RAMP_CYCLES   = CLK_HZ / 1000 * RAMP_MS;
  localparam int unsigned RESET_CYCLES  = CLK_HZ / 1000 * RAMP_RESET_MS;

  localparam int unsigned POS_W     = 12;
  localparam int unsigned BCD_W     = 13;
  localparam logic [11:0] POS_LOW   = 12'h000;
  localparam logic [11:0] POS_HIGH  = 12'hCCD;
  localparam int unsigned ACC_W     = 24;
  localparam int unsigned FRAC_W    = 8;

  localparam logic [3:0]  ADDR_STEP_RATE = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_TARGET    = 4'h8;
  localparam logic [15:0] STEP_RATE_RST  = 16'h0080;

  typedef struct packed {
    logic        coincide;
    logic        end_stop;
    logic        initiating;
    logic        running;
    logic [11:0] position;
  } status_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

endpackage : servo_pkg

// *** tb/motor_model.sv ***
// Behavioural stepper motor and capacitor shaft with its zero sensor.
`timescale 1ns/1ps
module motor_model #(
  parameter int START_POS = 10
) (
  input  wire logic       clk_i,
  input  wire logic [3:0] phase_i,
  output logic            zero_o
);
  int         pos  = START_POS;
  logic [3:0] last = 4'h0;
  initial zero_o = 1'b0;
  // The shaft turns one step per phase change; advancing order is upward.
  always @(posedge clk_i) begin
    if (phase_i != last && phase_i != 4'h0) begin
      if (last != 4'h0) begin
        if (phase_i == {last[2:0], last[3]}) pos = pos + 1;
        else pos = pos - 1;
      end
      last = phase_i;
    end
    zero_o <= (pos <= 0);
  end
endmodule : motor_model

// *** tb/servo_ctrl_chk.sv ***
// Port checker for the capacitor servo controller.
`timescale 1ns/1ps
module servo_ctrl_chk (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                aux_supply_pending_input_i,
  input wire logic                run_inhibit_input_i,
  input wire servo_pkg::bus_req_s bus_i,
  input wire logic [31:0]         rdata_o,
  input wire logic [3:0]          phase_o,
  input wire logic                high_supply_o,
  input wire logic                end_stop_output_o,
  input wire logic                end_stop_lamp_o,
  input wire logic                error_output_o,
  input wire logic                error_lamp_o
);
  logic [3:0] prev;
  logic       rd_q;
  logic [3:0] addr_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev   <= 4'h0;
      rd_q   <= 1'b0;
      addr_q <= 4'h0;
    end else begin
      prev   <= phase_o;
      rd_q   <= bus_i.rd;
      addr_q <= bus_i.addr;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A phase change shows two edges after the step that caused it.
  a_phase_gated: assert property (phase_o != prev && prev != 4'h0
    |-> $past(high_supply_o, 2))
    else $error("phase moved with motor supply low");
  a_phase_adjacent: assert property (phase_o != prev && prev != 4'h0
    |-> phase_o == {prev[2:0], prev[3]} || phase_o == {prev[0], prev[3:1]})
    else $error("phase skipped a state");
  a_end_lamp: assert property (end_stop_lamp_o == end_stop_output_o)
    else $error("end stop lamp differs from output");
  a_error_lamp: assert property (error_lamp_o == error_output_o)
    else $error("error lamp differs from output");
  a_inhibit_stop: assert property (run_inhibit_input_i [*6]
    |-> !high_supply_o) else $error("motor ran while inhibited");
  a_aux_stop: assert property (aux_supply_pending_input_i [*6]
    |-> !high_supply_o) else $error("motor ran before aux supplies");
  a_rdata_idle: assert property (!rd_q |-> rdata_o == 32'h0)
    else $error("read data outside read answer");
  a_end_pos: assert property (rd_q && addr_q == servo_pkg::ADDR_STATUS
    && rdata_o[14] |-> rdata_o[11:0] == servo_pkg::POS_LOW
    || rdata_o[11:0] == servo_pkg::POS_HIGH)
    else $error("end stop away from travel limit");
  c_run: cover property ($rose(high_supply_o));
  c_end: cover property ($rose(end_stop_output_o));
  c_err: cover property ($fell(error_output_o));
endmodule : servo_ctrl_chk
bind servo_ctrl servo_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .aux_supply_pending_input_i(aux_supply_pending_input_i),
  .run_inhibit_input_i(run_inhibit_input_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .phase_o(phase_o), .high_supply_o(high_supply_o),
  .end_stop_output_o(end_stop_output_o), .end_stop_lamp_o(end_stop_lamp_o),
  .error_output_o(error_output_o), .error_lamp_o(error_lamp_o));

// *** tb/testbench.sv ***
// Self-checking bench for the capacitor servo controller.
`timescale 1ns/1ps
module testbench;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                aux, inh, sel, zero, btn;
  logic [12:0]         panel;
  logic [11:0]         freq;
  servo_pkg::bus_req_s bus;
  logic [31:0]         rdata_o, v;
  logic [3:0]          phase_o;
  logic                high_supply_o, es_o, es_lamp, err_o, err_lamp;
  int                  error_cnt = 0;
  int                  compares = 0;
  always #12.5 clk_i = ~clk_i;
  servo_ctrl #(.RAMP_CYCLES(2560), .RESET_CYCLES(50)) u_servo_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .aux_supply_pending_input_i(aux),
    .run_inhibit_input_i(inh), .auto_manual_select_i(sel),
    .zero_position_sensor_i(zero), .start_button_i(btn),
    .panel_position_switches_i(panel), .freq_count_i(freq), .bus_i(bus),
    .rdata_o(rdata_o), .phase_o(phase_o), .high_supply_o(high_supply_o),
    .end_stop_output_o(es_o), .end_stop_lamp_o(es_lamp),
    .error_output_o(err_o), .error_lamp_o(err_lamp));
  motor_model u_motor_model (.clk_i(clk_i), .phase_i(phase_o), .zero_o(zero));
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
    d = rdata_o;
  endtask : rd
  // Waits for a run to start and end, then compares the counted position.
  task automatic move(input string n, input logic [11:0] p);
    int i;
    i = 0;
    while (high_supply_o !== 1'b1 && i < 3000) begin
      @(posedge clk_i);
      i++;
    end
    while (high_supply_o !== 1'b0 && i < 60000) begin
      @(posedge clk_i);
      i++;
    end
    chk({n, "_halt"}, {31'h0, high_supply_o}, 32'h0);
    repeat (100) @(posedge clk_i);
    rd(servo_pkg::ADDR_STATUS, v);
    chk(n, {20'h0, v[11:0]}, {20'h0, p});
  endtask : move
  task automatic end_sim;
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end
  initial begin
    {aux, inh, sel, btn, freq, bus} = {4'b1100, 12'h0, 38'h0};
    panel = 13'h0012;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(servo_pkg::ADDR_STEP_RATE, v);
    chk("rate_reset", v, 32'h80);
    wr(servo_pkg::ADDR_STEP_RATE, 32'hFFFF);
    wr(servo_pkg::ADDR_TARGET, 32'h123);
    rd(servo_pkg::ADDR_STEP_RATE, v);
    chk("rate", v, 32'hFFFF);
    rd(4'hC, v);
    chk("unmapped", v, 32'h0);
    aux <= 1'b0;
    inh <= 1'b0;
    move("init_zero", 12'h0);
    chk("low_stop", {31'h0, es_o}, 32'h1);
    move("first_pos", 12'd12);
    rd(servo_pkg::ADDR_TARGET, v);
    chk("bcd_target", v, 32'd12);
    chk("err_off", {31'h0, err_o}, 32'h0);
    panel <= 13'h0005;
    move("no_button", 12'd12);
    chk("err_on", {31'h0, err_o}, 32'h1);
    btn <= 1'b1;
    repeat (4) @(posedge clk_i);
    btn <= 1'b0;
    move("button", 12'd5);
    sel <= 1'b1;
    freq <= 12'd20;
    move("auto", 12'd20);
    rd(servo_pkg::ADDR_TARGET, v);
    chk("auto_target", v, 32'd20);
    inh <= 1'b1;
    freq <= 12'd30;
    move("inhibit", 12'd20);
    inh <= 1'b0;
    move("resume", 12'd30);
    freq <= 12'd0;
    move("to_low", 12'd0);
    chk("end_out", {31'h0, es_o}, 32'h1);
    chk("supply_hold", {31'h0, high_supply_o}, 32'h0);
    end_sim();
  end
endmodule : testbench
